// [shared/rcpm_defines.vh]
// Register offsets, field positions, reset values and timing counts for the reset/clock/power block
`ifndef RCPM_DEFINES_VH
`define RCPM_DEFINES_VH
// Register byte offsets
`define RCPM_OFF_LOWBAT 12'h000
`define RCPM_OFF_PMODE 12'h004
`define RCPM_OFF_PMCLR 12'h008
`define RCPM_OFF_INIT 12'h00C
`define RCPM_OFF_STATUS 12'h010
// Low-battery control fields
`define RCPM_LB_FLAG_BIT 0
`define RCPM_LB_TRIM_HI 7
`define RCPM_LB_TRIM_LO 5
`define RCPM_LB_TRIM_RST 3'h0
// Power mode fields
`define RCPM_PM_HALT_BIT 0
`define RCPM_PM_IDLE_BIT 1
// Initialization register fields
`define RCPM_INIT_DROPOUT_BIT 0
`define RCPM_INIT_CMODE0_BIT 1
`define RCPM_INIT_CMODE1_BIT 2
`define RCPM_INIT_PROTECT_BIT 3
// Clock source codes, written {bit1,bit0}
`define RCPM_CK_INTERNAL 2'h0
`define RCPM_CK_SQUARE 2'h1
`define RCPM_CK_CRYSTAL 2'h2
`define RCPM_CK_RC 2'h3
// Clock dividers
`define RCPM_DIV_INTERNAL 3'h2
`define RCPM_DIV_CRYSTAL 3'h4
`define RCPM_DIV_SQUARE 3'h1
// Timing counts
`define RCPM_HALT_STARTUP_CYC 16'h0040
`define RCPM_RESET_SEQ_CYC 16'h0040
`define RCPM_TIMER0_PERIOD 16'h2000
`endif

// [verilog/rcpm_ctrl.v]
// Reset, supply supervision, clock select and HALT/IDLE mode controller with APB slave
//
// Summary of operation
// - Brown-out holds reset, then sequence runs
// - Dropout enable set only in programming mode
// - Clear only in programming, unprotected
// - Flag reads 1 below threshold
// - Flag read-only, no action or interrupt
// - Three-bit trim picks eight levels, anytime
// - Power-on, brown-out or watchdog start reset
// - Reset clears ports, clock after start-up
// - Internal oscillator divided by two
// - Two-bit field selects clock source
// - Crystal/RC divide four, square undivided
// - Oscillator runs except HALT or external
// - Halt bit enters HALT, stops everything
// - HALT exits on wakeup after 64 cycles
// - Idle bit enters IDLE, timer keeps running
// - IDLE exits on timer or wakeup next cycle
`timescale 1ns/10ps
`default_nettype none
`include "rcpm_defines.vh"
module rcpm_ctrl #(
   parameter [15:0] RESET_SEQ_CYC = `RCPM_RESET_SEQ_CYC,
   parameter [15:0] HALT_STARTUP_CYC = `RCPM_HALT_STARTUP_CYC,
   parameter [15:0] TIMER0_PERIOD = `RCPM_TIMER0_PERIOD
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire power_on_detect,
   input wire supply_below_dropout,
   input wire supply_below_lowbat,
   input wire watchdog_reset_req,
   input wire multi_input_wakeup,
   input wire programming_mode,
   output reg core_reset_n,
   output reg port_reset_n,
   output reg core_clk_en,
   output reg osc_enable,
   output reg dropout_detect_on,
   output reg lowbat_detect_on,
   output reg [2:0] lowbat_trim,
   output reg [1:0] clock_source_select,
   output reg [2:0] clock_divide,
   output reg halt_active,
   output reg idle_active
);
   // ==========================================================
   // State codes
   localparam [2:0] ST_RESET = 3'h0;
   localparam [2:0] ST_SEQ = 3'h1;
   localparam [2:0] ST_RUN = 3'h2;
   localparam [2:0] ST_HALT = 3'h3;
   localparam [2:0] ST_START = 3'h4;
   localparam [2:0] ST_IDLE = 3'h5;

   // ==========================================================
   // Synchronisers for asynchronous inputs
   reg [1:0] sync_bod_r;
   reg [1:0] sync_lb_r;
   reg [1:0] sync_por_r;
   reg [1:0] sync_wdt_r;
   reg [1:0] sync_miw_r;
   reg [1:0] sync_prog_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_bod_r <= 2'h0;
         sync_lb_r <= 2'h0;
         sync_por_r <= 2'h3;
         sync_wdt_r <= 2'h0;
         sync_miw_r <= 2'h0;
         sync_prog_r <= 2'h0;
      end else begin
         sync_bod_r <= {sync_bod_r[0], supply_below_dropout};
         sync_lb_r <= {sync_lb_r[0], supply_below_lowbat};
         sync_por_r <= {sync_por_r[0], power_on_detect};
         sync_wdt_r <= {sync_wdt_r[0], watchdog_reset_req};
         sync_miw_r <= {sync_miw_r[0], multi_input_wakeup};
         sync_prog_r <= {sync_prog_r[0], programming_mode};
      end
   end
   wire bod_s = sync_bod_r[1];
   wire lb_s = sync_lb_r[1];
   wire por_s = sync_por_r[1];
   wire wdt_s = sync_wdt_r[1];
   wire miw_s = sync_miw_r[1];
   wire prog_s = sync_prog_r[1];

   // ==========================================================
   // Registers
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [15:0] count_r;
   reg [15:0] count_nxt;
   reg [15:0] timer0_r;
   reg [2:0] trim_r;
   reg dropout_en_r;
   reg protect_r;
   reg [1:0] clock_source_select_r;
   reg lowbat_flag_r;
   reg pmc_pending_r;

   // APB decode
   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire hit_lb = (paddr == `RCPM_OFF_LOWBAT);
   wire hit_pm = (paddr == `RCPM_OFF_PMODE);
   wire hit_pc = (paddr == `RCPM_OFF_PMCLR);
   wire hit_in = (paddr == `RCPM_OFF_INIT);
   wire hit_st = (paddr == `RCPM_OFF_STATUS);
   wire mapped = hit_lb | hit_pm | hit_pc | hit_in | hit_st;
   wire pm_wr = wr & hit_pm & pstrb[0] & (state_r == ST_RUN);
   wire halt_req = pm_wr & pwdata[`RCPM_PM_HALT_BIT];
   wire idle_req = pm_wr & pwdata[`RCPM_PM_IDLE_BIT];
   wire dropout_live = dropout_en_r & bod_s & (state_r != ST_HALT) & (state_r != ST_IDLE);
   wire any_reset = por_s | dropout_live | wdt_s;
   wire timer0_ovf = (timer0_r == TIMER0_PERIOD - 16'h0001);

   // ==========================================================
   // Mode sequencer next state
   always @* begin
      state_nxt = state_r;
      count_nxt = count_r;
      case (state_r)
         ST_RESET: begin
            count_nxt = 16'h0000;
            if (!any_reset) begin
               state_nxt = ST_SEQ;
            end
         end
         ST_SEQ: begin
            count_nxt = count_r + 16'h0001;
            if (count_r == RESET_SEQ_CYC - 16'h0001) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            count_nxt = 16'h0000;
            if (halt_req) begin
               state_nxt = ST_HALT;
            end else if (idle_req) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_HALT: begin
            count_nxt = 16'h0000;
            if (miw_s) begin
               state_nxt = ST_START;
            end
         end
         ST_START: begin
            count_nxt = count_r + 16'h0001;
            if (count_r == HALT_STARTUP_CYC - 16'h0001) begin
               state_nxt = ST_RUN;
            end
         end
         ST_IDLE: begin
            count_nxt = 16'h0000;
            if (miw_s | timer0_ovf) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RESET;
            count_nxt = 16'h0000;
         end
      endcase
      if (any_reset) begin
         state_nxt = ST_RESET;
         count_nxt = 16'h0000;
      end
   end

   // Sequencer, timer 0 and outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_RESET;
         count_r <= 16'h0000;
         timer0_r <= 16'h0000;
         core_reset_n <= 1'b0;
         port_reset_n <= 1'b0;
         core_clk_en <= 1'b0;
         osc_enable <= 1'b1;
         dropout_detect_on <= 1'b0;
         lowbat_detect_on <= 1'b0;
         halt_active <= 1'b0;
         idle_active <= 1'b0;
         pmc_pending_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         count_r <= count_nxt;
         // Timer 0 stops only in HALT and reset
         if (state_nxt == ST_HALT || state_nxt == ST_RESET || timer0_ovf) begin
            timer0_r <= 16'h0000;
         end else begin
            timer0_r <= timer0_r + 16'h0001;
         end
         core_reset_n <= (state_nxt == ST_RUN) | (state_nxt == ST_HALT) | (state_nxt == ST_START)
                         | (state_nxt == ST_IDLE);
         port_reset_n <= (state_nxt != ST_RESET) & (state_nxt != ST_SEQ);
         core_clk_en <= (state_nxt == ST_RUN);
         osc_enable <= (state_nxt != ST_HALT) & (clock_source_select_r == `RCPM_CK_INTERNAL);
         dropout_detect_on <= dropout_en_r & (state_nxt != ST_HALT) & (state_nxt != ST_IDLE);
         lowbat_detect_on <= (state_nxt != ST_HALT) & (state_nxt != ST_IDLE);
         halt_active <= (state_nxt == ST_HALT);
         idle_active <= (state_nxt == ST_IDLE);
         // Pending until software writes clear register after exit
         if ((state_r == ST_START || state_r == ST_IDLE) && state_nxt == ST_RUN) begin
            pmc_pending_r <= 1'b1;
         end else if (wr & hit_pc) begin
            pmc_pending_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_r <= `RCPM_LB_TRIM_RST;
         dropout_en_r <= 1'b0;
         protect_r <= 1'b0;
         clock_source_select_r <= `RCPM_CK_INTERNAL;
         lowbat_flag_r <= 1'b0;
      end else begin
         if (wr & hit_lb & pstrb[0]) begin
            trim_r <= pwdata[`RCPM_LB_TRIM_HI:`RCPM_LB_TRIM_LO];
         end
         if (wr & hit_in & pstrb[0] & prog_s) begin
            if (pwdata[`RCPM_INIT_DROPOUT_BIT]) begin
               dropout_en_r <= 1'b1;
            end else if (!protect_r) begin
               dropout_en_r <= 1'b0;
            end
            clock_source_select_r <= {pwdata[`RCPM_INIT_CMODE1_BIT], pwdata[`RCPM_INIT_CMODE0_BIT]};
            protect_r <= protect_r | pwdata[`RCPM_INIT_PROTECT_BIT];
         end
         // Flag follows comparator only while detection is powered
         if (lowbat_detect_on) begin
            lowbat_flag_r <= lb_s;
         end
      end
   end

   // Clock source and divider outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lowbat_trim <= `RCPM_LB_TRIM_RST;
         clock_source_select <= `RCPM_CK_INTERNAL;
         clock_divide <= `RCPM_DIV_INTERNAL;
      end else begin
         lowbat_trim <= trim_r;
         clock_source_select <= clock_source_select_r;
         case (clock_source_select_r)
            `RCPM_CK_INTERNAL: clock_divide <= `RCPM_DIV_INTERNAL;
            `RCPM_CK_SQUARE: clock_divide <= `RCPM_DIV_SQUARE;
            default: clock_divide <= `RCPM_DIV_CRYSTAL;
         endcase
      end
   end

   // ==========================================================
   // APB slave: one wait state, error on unmapped address
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h0000_0000;
      if (hit_lb) begin
         rd_nxt[`RCPM_LB_TRIM_HI:`RCPM_LB_TRIM_LO] = trim_r;
         rd_nxt[`RCPM_LB_FLAG_BIT] = lowbat_flag_r;
      end else if (hit_in) begin
         rd_nxt[`RCPM_INIT_DROPOUT_BIT] = dropout_en_r;
         rd_nxt[`RCPM_INIT_CMODE0_BIT] = clock_source_select_r[0];
         rd_nxt[`RCPM_INIT_CMODE1_BIT] = clock_source_select_r[1];
         rd_nxt[`RCPM_INIT_PROTECT_BIT] = protect_r;
      end else if (hit_st) begin
         rd_nxt[2:0] = state_r;
         rd_nxt[3] = pmc_pending_r;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= ~mapped;
         end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end
endmodule // rcpm_ctrl
`default_nettype wire

// [testbench/rcpm_ctrl_properties.sv]
// Port-level checks for the reset, clock and power mode controller
`timescale 1ns/10ps
`default_nettype none
module rcpm_ctrl_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic supply_below_dropout,
   input wire logic watchdog_reset_req,
   input wire logic core_reset_n,
   input wire logic core_clk_en,
   input wire logic osc_enable,
   input wire logic dropout_detect_on,
   input wire logic lowbat_detect_on,
   input wire logic [2:0] lowbat_trim,
   input wire logic [1:0] clock_source_select,
   input wire logic [2:0] clock_divide,
   input wire logic halt_active,
   input wire logic idle_active
);
   // ==========================================
   // One clock domain for every check
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_APB_WAIT: assert property (psel && penable && !pready |=> pready) else $error("pready late");
   AST_ERR_PULSE: assert property (pslverr |-> pready) else $error("pslverr without pready");
   AST_TRIM: assert property (psel && penable && pready && pwrite && paddr == 12'h000
      |-> ##2 lowbat_trim == $past(pwdata[7:5], 2)) else $error("trim not taken");
   AST_BROWNOUT: assert property (dropout_detect_on && supply_below_dropout [*3]
      |-> ##[0:3] !core_reset_n) else $error("no reset on dropout");
   AST_WATCHDOG: assert property (watchdog_reset_req [*3] |-> ##[0:3] !core_reset_n)
      else $error("no reset on watchdog");
   AST_CLK_HELD: assert property (!core_reset_n || halt_active |-> !core_clk_en)
      else $error("clock runs in reset or halt");
   AST_DIVIDE: assert property (clock_divide == ((clock_source_select == 2'h0) ? 3'h2 :
      (clock_source_select == 2'h1) ? 3'h1 : 3'h4)) else $error("divider wrong");
   AST_HALT_OFF: assert property (halt_active |-> !osc_enable && !dropout_detect_on && !lowbat_detect_on)
      else $error("halt leaves systems on");
   AST_IDLE_MIX: assert property (idle_active |-> (osc_enable == (clock_source_select == 2'h0))
      && !dropout_detect_on && !lowbat_detect_on)
      else $error("idle power mix wrong");
   AST_ONE_MODE: assert property (!(halt_active && idle_active)) else $error("both modes");
   AST_OSC_ON: assert property (clock_source_select == 2'h0 && !halt_active |-> osc_enable)
      else $error("oscillator off");
endmodule // rcpm_ctrl_props
bind rcpm_ctrl rcpm_ctrl_props i_rcpm_ctrl_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .supply_below_dropout(supply_below_dropout), .watchdog_reset_req(watchdog_reset_req),
   .core_reset_n(core_reset_n), .core_clk_en(core_clk_en), .osc_enable(osc_enable),
   .dropout_detect_on(dropout_detect_on), .lowbat_detect_on(lowbat_detect_on), .lowbat_trim(lowbat_trim),
   .clock_source_select(clock_source_select), .clock_divide(clock_divide), .halt_active(halt_active),
   .idle_active(idle_active));
`default_nettype wire

// [testbench/rcpm_ctrl_test.sv]
// Self-checking bench for the reset, clock and power mode controller
`timescale 1ns/10ps
`default_nettype none
`include "rcpm_defines.vh"
module rcpm_ctrl_test;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic power_on_detect = 1'b1, supply_below_dropout = 1'b0, supply_below_lowbat = 1'b0;
   logic watchdog_reset_req = 1'b0, multi_input_wakeup = 1'b0, programming_mode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, err, core_reset_n, port_reset_n, core_clk_en, osc_enable;
   logic dropout_detect_on, lowbat_detect_on, halt_active, idle_active;
   logic [2:0] lowbat_trim, clock_divide;
   logic [1:0] clock_source_select;
   int num_errors = 0, n_tests = 0, n;
   rcpm_ctrl #(.RESET_SEQ_CYC(16'h0004), .HALT_STARTUP_CYC(16'h0004), .TIMER0_PERIOD(16'h0020)) i_rcpm_ctrl (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_on_detect(power_on_detect), .supply_below_dropout(supply_below_dropout),
      .supply_below_lowbat(supply_below_lowbat), .watchdog_reset_req(watchdog_reset_req),
      .multi_input_wakeup(multi_input_wakeup), .programming_mode(programming_mode),
      .core_reset_n(core_reset_n), .port_reset_n(port_reset_n), .core_clk_en(core_clk_en),
      .osc_enable(osc_enable), .dropout_detect_on(dropout_detect_on), .lowbat_detect_on(lowbat_detect_on),
      .lowbat_trim(lowbat_trim), .clock_source_select(clock_source_select), .clock_divide(clock_divide),
      .halt_active(halt_active), .idle_active(idle_active));
   // ==========================================
   // Clock and shared tasks
   always #20 pclk = ~pclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      if (num_errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) num_errors++;
   endtask
   task automatic wait_run;
      for (n = 0; n < 200 && core_clk_en !== 1'b1; n++) @(posedge pclk);
      check({core_reset_n, port_reset_n, core_clk_en}, 3'h7);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_lowbat;
      apb(1'b0, `RCPM_OFF_LOWBAT, 32'h0);
      check(rd & 32'hE1, 32'h0);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `RCPM_OFF_LOWBAT, i << 5);
         cyc(2);
         check(lowbat_trim, i);
      end
      supply_below_lowbat <= 1'b1;
      cyc(4);
      apb(1'b1, `RCPM_OFF_LOWBAT, 32'h0);
      apb(1'b0, `RCPM_OFF_LOWBAT, 32'h0);
      check(rd & 32'hE1, 32'h1);
      supply_below_lowbat <= 1'b0;
      cyc(4);
      apb(1'b0, `RCPM_OFF_LOWBAT, 32'h0);
      check(rd & 32'hE1, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
   endtask
   task automatic t_init;
      programming_mode <= 1'b1;
      cyc(4);
      for (int k = 3; k >= 0; k--) begin
         apb(1'b1, `RCPM_OFF_INIT, (k << 1) | 1);
         cyc(3);
         check(clock_source_select, k);
         check(clock_divide, (k == 0) ? 2 : (k == 1) ? 1 : 4);
      end
      apb(1'b1, `RCPM_OFF_INIT, 32'h0);
      apb(1'b0, `RCPM_OFF_INIT, 32'h0);
      check(rd & 32'h1, 32'h0);
      apb(1'b1, `RCPM_OFF_INIT, 32'h9);
      apb(1'b1, `RCPM_OFF_INIT, 32'h0);
      apb(1'b0, `RCPM_OFF_INIT, 32'h0);
      check(rd & 32'h1, 32'h1);
      programming_mode <= 1'b0;
      cyc(4);
      apb(1'b1, `RCPM_OFF_INIT, 32'h4);
      apb(1'b0, `RCPM_OFF_INIT, 32'h0);
      check(rd & 32'h7, 32'h1);
   endtask
   task automatic t_brown;
      supply_below_dropout <= 1'b1;
      cyc(5);
      check({core_reset_n, port_reset_n}, 2'h0);
      supply_below_dropout <= 1'b0;
      wait_run();
      watchdog_reset_req <= 1'b1;
      cyc(5);
      check({core_reset_n, port_reset_n}, 2'h0);
      watchdog_reset_req <= 1'b0;
      wait_run();
   endtask
   task automatic t_halt;
      apb(1'b1, `RCPM_OFF_PMODE, 32'h3);
      cyc(2);
      check({halt_active, idle_active, osc_enable}, 3'h4);
      apb(1'b0, `RCPM_OFF_PMODE, 32'h0);
      check(rd, 32'h0);
      multi_input_wakeup <= 1'b1;
      for (n = 0; n < 100 && core_clk_en !== 1'b1; n++) @(posedge pclk);
      check(n >= 5 && n <= 10, 1'b1);
      check(halt_active, 1'b0);
      multi_input_wakeup <= 1'b0;
      apb(1'b1, `RCPM_OFF_PMCLR, 32'h0);
      cyc(250);
      apb(1'b0, `RCPM_OFF_LOWBAT, 32'h0);
      check(rd & 32'h1, 32'h0);
   endtask
   task automatic t_idle;
      apb(1'b1, `RCPM_OFF_PMODE, 32'h2);
      cyc(2);
      check({idle_active, osc_enable, lowbat_detect_on}, 3'h6);
      for (n = 0; n < 200 && idle_active === 1'b1; n++) @(posedge pclk);
      check(n <= 34, 1'b1);
      apb(1'b1, `RCPM_OFF_PMCLR, 32'h0);
      apb(1'b1, `RCPM_OFF_PMODE, 32'h2);
      multi_input_wakeup <= 1'b1;
      cyc(5);
      check(idle_active, 1'b0);
      multi_input_wakeup <= 1'b0;
      apb(1'b1, `RCPM_OFF_PMCLR, 32'h0);
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      power_on_detect <= 1'b0;
      wait_run();
      check(clock_divide, 3'h2);
      t_lowbat();
      t_init();
      t_brown();
      t_halt();
      t_idle();
      give_verdict();
   end
   initial begin
      #1000000;
      num_errors++;
      give_verdict();
   end
endmodule // rcpm_ctrl_test
`default_nettype wire
